/* logic/nbl_cfg.svh */
// Timing counts and command codes for the NAND host sequencer.
// Assumes a 100 MHz system clock; wait times are in microseconds, the strobe phase count in clk_i cycles.
`ifndef NBL_CFG_SVH
`define NBL_CFG_SVH

`define NBL_CLK_NS          10
`define NBL_CMD_RESET       8'hff
`define NBL_CMD_STATUS      8'h70
`define NBL_CMD_READ_ADDR   8'h00
`define NBL_CMD_READ_START  8'h30
`define NBL_READ_LAT_US     25
`define NBL_RST_RD_US       6
`define NBL_RST_PG_US       10
`define NBL_RST_ER_US       500
`define NBL_MAX_PROGS       2
// Strobe phase lengths: count 3 holds each timed phase 4 cycles (40 ns), 80 ns per low-high pair
`define NBL_PHASE_CYC       3
`define NBL_STS_READY_BIT   6

`endif

/* logic/nbl_pkg.sv */
// Types shared by the NAND host sequencer files.
// Assumes nbl_cfg.svh supplies the numeric constants.
package nbl_pkg;

   typedef enum logic [2:0] {
      NBL_OP_CMD    = 3'h0,
      NBL_OP_ADDR   = 3'h1,
      NBL_OP_DIN    = 3'h2,
      NBL_OP_DOUT   = 3'h3,
      NBL_OP_WAIT   = 3'h4,
      NBL_OP_STATUS = 3'h5
   } nbl_op_t;

   typedef enum logic [1:0] {
      NBL_AB_READ  = 2'h0,
      NBL_AB_PROG  = 2'h1,
      NBL_AB_ERASE = 2'h2
   } nbl_abort_t;

   typedef struct packed {
      nbl_op_t    op;
      nbl_abort_t abort;
      logic [7:0] data;
   } nbl_req_t;

   typedef struct packed {
      logic       cs_n;
      logic       cmd_latch;
      logic       addr_latch;
      logic       write_n;
      logic       read_strobe_n;
      logic       io_oe;
      logic [7:0] io_out;
   } nbl_pins_t;

endpackage

/* logic/nbl_phase_timer.sv */
// Down counter used for strobe phases and device wait times.
// Assumes loads come from logic on clk_i.
`timescale 1ns/1ps
module nbl_phase_timer (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        load_i,
   input  wire logic [19:0] count_i,
   output logic             done_o
);
   logic [19:0] cnt_r;

   assign done_o = (cnt_r == 20'h00000);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         cnt_r <= 20'h00000;
      else if (load_i)
         cnt_r <= count_i;
      else if (!done_o)
         cnt_r <= cnt_r - 20'h00001;
   end
endmodule

/* logic/nbl_host.sv */
// Host-side NAND bus sequencer: one byte cycle or wait per request.
// Assumes ready/busy is open drain with an external pull-up, async to clk_i.
`timescale 1ns/1ps
`include "nbl_cfg.svh"

// How it works
// - After read start wait the full 25 us, and for ready, before fetching.
// - After reset command wait 6, 10 or 500 us by aborted operation.
// - At most two program confirms (10h) are taken between erases, counted over all pages.
// - Status poll latches 70h then samples the byte while read strobe low.
// - Full address is four address cycles: two column, two page bytes.
module nbl_host (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             req_valid_i,
   input  wire nbl_pkg::nbl_req_t req_i,
   output logic                  req_ready_o,
   output logic                  rsp_valid_o,
   output logic [7:0]            rsp_data_o,
   output logic                  prog_refused_o,
   input  wire logic             ready_busy_out_i,
   input  wire logic [7:0]       io_i,
   output nbl_pkg::nbl_pins_t    pins_o
);
   typedef enum logic [2:0] {
      NBL_S_IDLE  = 3'h0,
      NBL_S_LOW   = 3'h1,
      NBL_S_HIGH  = 3'h2,
      NBL_S_WAITT = 3'h3,
      NBL_S_WAITR = 3'h4
   } nbl_state_t;

   localparam logic [19:0] PH_CYC = 20'(`NBL_PHASE_CYC);
   localparam logic [19:0] RD_CYC =
      20'(`NBL_READ_LAT_US * 1000 / `NBL_CLK_NS);
   localparam logic [19:0] RST_RD_CYC =
      20'(`NBL_RST_RD_US * 1000 / `NBL_CLK_NS);
   localparam logic [19:0] RST_PG_CYC =
      20'(`NBL_RST_PG_US * 1000 / `NBL_CLK_NS);
   localparam logic [19:0] RST_ER_CYC =
      20'(`NBL_RST_ER_US * 1000 / `NBL_CLK_NS);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic       rb_s1_r, rb_s2_r;
   logic [7:0] io_s1_r, io_s2_r;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rb_s1_r <= 1'b1;
         rb_s2_r <= 1'b1;
         io_s1_r <= 8'h00;
         io_s2_r <= 8'h00;
      end else begin
         rb_s1_r <= ready_busy_out_i;
         rb_s2_r <= rb_s1_r;
         io_s1_r <= io_i;
         io_s2_r <= io_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state
   nbl_state_t        st_r, st_nxt;
   nbl_pkg::nbl_req_t cur_r;
   nbl_pkg::nbl_pins_t pins_r, pins_nxt;
   logic [7:0]        last_cmd_r;
   logic [1:0]        addr_cnt_r;
   logic [1:0]        prog_cnt_r;
   logic              tm_load;
   logic [19:0]       tm_count;
   logic              tm_done;
   logic              rsp_v_r;
   logic [7:0]        rsp_d_r;

   nbl_phase_timer u_timer (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .load_i    (tm_load),
      .count_i   (tm_count),
      .done_o    (tm_done)
   );

   wire is_write  = (cur_r.op == nbl_pkg::NBL_OP_CMD) ||
                    (cur_r.op == nbl_pkg::NBL_OP_ADDR) ||
                    (cur_r.op == nbl_pkg::NBL_OP_DIN);
   wire is_reset  = (cur_r.op == nbl_pkg::NBL_OP_CMD) &&
                    (cur_r.data == `NBL_CMD_RESET);
   wire is_start  = (cur_r.op == nbl_pkg::NBL_OP_CMD) &&
                    (cur_r.data == `NBL_CMD_READ_START);
   wire is_prog   = (cur_r.op == nbl_pkg::NBL_OP_DIN) &&
                    (last_cmd_r == 8'h80);
   // Program count refused once the limit is hit; erase (60h) clears it
   wire prog_full = (prog_cnt_r == 2'(`NBL_MAX_PROGS));
   wire take      = req_valid_i && (st_r == NBL_S_IDLE);
   wire refuse    = take && (req_i.op == nbl_pkg::NBL_OP_CMD) &&
                    (req_i.data == 8'h10) && prog_full;
   wire [19:0] rst_cyc = (cur_r.abort == nbl_pkg::NBL_AB_READ) ? RST_RD_CYC :
                         (cur_r.abort == nbl_pkg::NBL_AB_PROG) ? RST_PG_CYC :
                                                                RST_ER_CYC;

   assign req_ready_o    = (st_r == NBL_S_IDLE);
   assign rsp_valid_o    = rsp_v_r;
   assign rsp_data_o     = rsp_d_r;
   assign prog_refused_o = refuse;
   assign pins_o         = pins_r;

   always_comb begin
      st_nxt   = st_r;
      pins_nxt = pins_r;
      tm_load  = 1'b0;
      tm_count = PH_CYC;
      unique case (st_r)
         NBL_S_IDLE: begin
            pins_nxt.write_n       = 1'b1;
            pins_nxt.read_strobe_n = 1'b1;
            if (take && !refuse) begin
               // Chip select held low from here; never raised while busy
               pins_nxt.cs_n = 1'b0;
               if (req_i.op == nbl_pkg::NBL_OP_WAIT) begin
                  st_nxt = NBL_S_WAITR;
               end else begin
                  pins_nxt.cmd_latch  =
                     (req_i.op == nbl_pkg::NBL_OP_CMD);
                  pins_nxt.addr_latch =
                     (req_i.op == nbl_pkg::NBL_OP_ADDR);
                  pins_nxt.io_out = req_i.data;
                  pins_nxt.io_oe  =
                     (req_i.op != nbl_pkg::NBL_OP_DOUT) &&
                     (req_i.op != nbl_pkg::NBL_OP_STATUS);
                  tm_load = 1'b1;
                  st_nxt  = NBL_S_LOW;
               end
            end
         end
         NBL_S_LOW: begin
            // Strobes only drop once ready is seen, so busy is never broken
            if (tm_done && rb_s2_r) begin
               pins_nxt.write_n       = !is_write;
               pins_nxt.read_strobe_n = is_write;
               tm_load = 1'b1;
               st_nxt  = NBL_S_HIGH;
            end
         end
         NBL_S_HIGH: begin
            if (tm_done) begin
               // Latches and byte stay up through the write rise
               pins_nxt.write_n       = 1'b1;
               pins_nxt.read_strobe_n = 1'b1;
               if (is_reset) begin
                  tm_load  = 1'b1;
                  tm_count = rst_cyc;
                  st_nxt   = NBL_S_WAITT;
               end else if (is_start) begin
                  tm_load  = 1'b1;
                  tm_count = RD_CYC;
                  st_nxt   = NBL_S_WAITT;
               end else begin
                  tm_load = 1'b1;
                  st_nxt  = NBL_S_WAITR;
               end
            end
         end
         NBL_S_WAITT: begin
            // Release one cycle after write rise, giving latch hold time
            pins_nxt.io_oe      = 1'b0;
            pins_nxt.cmd_latch  = 1'b0;
            pins_nxt.addr_latch = 1'b0;
            if (tm_done)
               st_nxt = NBL_S_WAITR;
         end
         NBL_S_WAITR: begin
            pins_nxt.io_oe      = 1'b0;
            pins_nxt.cmd_latch  = 1'b0;
            pins_nxt.addr_latch = 1'b0;
            // Timer keeps the recovery gap before the next strobe
            if (tm_done && rb_s2_r)
               st_nxt = NBL_S_IDLE;
         end
         default: st_nxt = NBL_S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_r       <= NBL_S_IDLE;
         pins_r     <= '{cs_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
                        write_n: 1'b1, read_strobe_n: 1'b1, io_oe: 1'b0,
                        io_out: 8'h00};
         cur_r      <= '0;
         last_cmd_r <= 8'h00;
         addr_cnt_r <= 2'h0;
         prog_cnt_r <= 2'h0;
         rsp_v_r    <= 1'b0;
         rsp_d_r    <= 8'h00;
      end else begin
         st_r    <= st_nxt;
         pins_r  <= pins_nxt;
         rsp_v_r <= 1'b0;
         if (take && !refuse) begin
            cur_r <= req_i;
            if (req_i.op == nbl_pkg::NBL_OP_CMD) begin
               last_cmd_r <= req_i.data;
               addr_cnt_r <= 2'h0;
               if (req_i.data == 8'h60)
                  prog_cnt_r <= 2'h0;
               else if (req_i.data == 8'h10)
                  prog_cnt_r <= prog_cnt_r + 2'h1;
            end
            if (req_i.op == nbl_pkg::NBL_OP_ADDR)
               addr_cnt_r <= addr_cnt_r + 2'h1;
         end
         // Sample the byte at the end of the read low phase
         if (st_r == NBL_S_HIGH && tm_done && !is_write) begin
            rsp_v_r <= 1'b1;
            rsp_d_r <= io_s2_r;
         end
      end
   end

   chk_cs_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !rb_s2_r |-> !pins_r.cs_n || st_r == NBL_S_IDLE)
      else $error("chip select high while busy");
   chk_latch_excl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(pins_r.cmd_latch && pins_r.addr_latch))
      else $error("both latch strobes high");
   chk_we_cs: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !pins_r.write_n |-> !pins_r.cs_n)
      else $error("write strobe with chip deselected");
   chk_start_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st_r == NBL_S_HIGH && tm_done && is_start) |=> st_r == NBL_S_WAITT)
      else $error("no read latency wait");
   chk_prog_limit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      prog_cnt_r <= 2'(`NBL_MAX_PROGS))
      else $error("program count over limit");
   chk_addr_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(pins_r.write_n) && cur_r.op == nbl_pkg::NBL_OP_ADDR
      |-> pins_r.addr_latch)
      else $error("address strobe without latch");
   chk_din_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(pins_r.write_n) && cur_r.op == nbl_pkg::NBL_OP_DIN
      |-> is_prog && !pins_r.cmd_latch && !pins_r.addr_latch)
      else $error("data strobe outside a load");
   chk_addr_four: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      take && !refuse && req_i.op == nbl_pkg::NBL_OP_CMD &&
      req_i.data == `NBL_CMD_READ_START |-> addr_cnt_r == 2'h0)
      else $error("read start after partial address");
   chk_strobe_rdy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $fell(pins_r.read_strobe_n) |-> $past(rb_s2_r))
      else $error("read strobe while busy");
   chk_status_rsp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(pins_r.read_strobe_n) |-> rsp_v_r)
      else $error("no response after read strobe");
endmodule

/* verif/nbl_dev_model.sv */
// Behavioural NAND device seen only through the host's pins.
// Assumes the bench resolves the shared I/O bus and the ready pull-up.
`timescale 1ns/1ps
module nbl_dev_model #(
   parameter int READ_NS = 20000,
   parameter int RST_NS  = 3000,
   parameter int PROG_NS = 4000
) (
   input  wire nbl_pkg::nbl_pins_t pins_i,
   input  wire logic [7:0]         io_i,
   output logic [7:0]              dout_o,
   output logic                    dout_oe_o,
   output logic                    busy_o
);
   logic [7:0] cmd_q  = 8'h00;
   logic [7:0] data_q = 8'h00;
   logic [7:0] col_q  = 8'h00;
   logic [7:0] addr_q [4] = '{default: 8'h00};
   logic       stat_q = 1'b0;
   int         addr_n = 0;
   int         dly    = 0;
   event       go_e;

   initial busy_o = 1'b0;
   initial dout_o = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Only status and reset commands get through while busy
   always @(posedge pins_i.write_n) begin
      if (!pins_i.cs_n) begin
         if (pins_i.cmd_latch && (!busy_o || io_i inside {8'h70, 8'hff})) begin
            cmd_q = io_i;
            stat_q = (io_i == 8'h70);
            addr_n = 0;
            dly = io_i == 8'h30 ? READ_NS : io_i == 8'hff ? RST_NS
                : io_i == 8'h10 ? PROG_NS : 0;
            if (dly > 0)
               -> go_e;
         end else if (!busy_o && pins_i.addr_latch) begin
            addr_q[addr_n[1:0]] = io_i;
            addr_n++;
            col_q = addr_q[0];
         end else if (!busy_o && !pins_i.cmd_latch) begin
            data_q = io_i;
         end
      end
   end

   always begin
      @(go_e);
      busy_o = 1'b1;
      #(dly);
      busy_o = 1'b0;
   end

   always @(negedge pins_i.read_strobe_n) begin
      if (!pins_i.cs_n && !busy_o) begin
         dout_o = stat_q ? {1'b0, !busy_o, 6'h00} : col_q ^ 8'ha5;
         if (!stat_q)
            col_q++;
      end
   end

   assign dout_oe_o = !pins_i.cs_n && !pins_i.read_strobe_n && !busy_o;
endmodule

/* verif/tb.sv */
// Self-checking bench for the NAND host sequencer with a device model.
// Assumes nbl_cfg.svh on the include path and a 100 MHz clock.
`timescale 1ns/1ps
`include "nbl_cfg.svh"
module tb;
   logic               clk_i     = 1'b0;
   logic               sys_rst_i = 1'b1;
   logic               req_valid = 1'b0;
   nbl_pkg::nbl_req_t  req       = '0;
   logic               req_ready, rsp_valid, prog_refused, refd;
   logic               dev_oe, dev_busy, rb_w;
   logic [7:0]         rsp_data, dev_q, io_w, got;
   nbl_pkg::nbl_pins_t pins;
   int                 fails = 0;
   int                 total_checks = 0;
   int                 viol = 0;
   int                 cyc;

   initial forever #5 clk_i = ~clk_i;

   // Pull-up on ready; a released bus shows the inverse, never a stale byte
   assign rb_w = !dev_busy;
   assign io_w = pins.io_oe ? pins.io_out : dev_oe ? dev_q : ~dev_q;

   nbl_host dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
      .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
      .prog_refused_o(prog_refused), .ready_busy_out_i(rb_w),
      .io_i(io_w), .pins_o(pins));
   nbl_dev_model dev_u (.pins_i(pins), .io_i(io_w), .dout_o(dev_q),
      .dout_oe_o(dev_oe), .busy_o(dev_busy));

   always @(posedge clk_i)
      if (rb_w === 1'b0 && (pins.cs_n !== 1'b0 || pins.write_n !== 1'b1
          || pins.read_strobe_n !== 1'b1))
         viol++;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic send(input nbl_pkg::nbl_op_t op, input logic [7:0] d,
      input nbl_pkg::nbl_abort_t ab = nbl_pkg::NBL_AB_READ);
      int n;
      n = 0;
      @(negedge clk_i);
      got = 8'hxx;
      req = '{op: op, abort: ab, data: d};
      req_valid = 1'b1;
      #1;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         #1;
         n++;
      end
      refd = prog_refused;
      @(negedge clk_i);
      req_valid = 1'b0;
      cyc = 0;
      // Long enough for an erase abort, the slowest wait
      while (req_ready !== 1'b1 && cyc < 60000) begin
         @(negedge clk_i);
         if (rsp_valid === 1'b1)
            got = rsp_data;
         cyc++;
      end
      if (n >= 100 || cyc >= 60000) begin
         fails++;
         end_of_test();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_read();
      logic [7:0] ad [4] = '{8'h03, 8'h00, 8'h05, 8'h00};
      int         rd_cyc = `NBL_READ_LAT_US * 1000 / `NBL_CLK_NS;
      send(nbl_pkg::NBL_OP_CMD, `NBL_CMD_READ_ADDR);
      for (int i = 0; i < 4; i++)
         send(nbl_pkg::NBL_OP_ADDR, ad[i]);
      chk("col_lo", dev_u.addr_q[0], 8'h03);
      chk("page_lo", dev_u.addr_q[2], 8'h05);
      send(nbl_pkg::NBL_OP_CMD, `NBL_CMD_READ_START);
      chk("cmd_reg", dev_u.cmd_q, 8'h30);
      chk("ready_after", rb_w, 1'b1);
      chk("lat_wait", cyc >= rd_cyc, 1'b1);
      send(nbl_pkg::NBL_OP_DOUT, 8'h00);
      chk("byte0", got, 8'ha6);
      send(nbl_pkg::NBL_OP_DOUT, 8'h00);
      chk("byte1", got, 8'ha1);
      $display("t_read done");
   endtask

   task automatic t_status();
      send(nbl_pkg::NBL_OP_CMD, `NBL_CMD_STATUS);
      send(nbl_pkg::NBL_OP_STATUS, 8'h00);
      chk("status", got, 8'h40);
      $display("t_status done");
   endtask

   task automatic t_prog();
      send(nbl_pkg::NBL_OP_CMD, 8'h80);
      for (int i = 0; i < 4; i++)
         send(nbl_pkg::NBL_OP_ADDR, 8'h00);
      send(nbl_pkg::NBL_OP_DIN, 8'h3c);
      chk("din", dev_u.data_q, 8'h3c);
      for (int i = 0; i < 3; i++) begin
         send(nbl_pkg::NBL_OP_CMD, 8'h10);
         chk("refuse", refd, i == 2);
         send(nbl_pkg::NBL_OP_WAIT, 8'h00);
      end
      send(nbl_pkg::NBL_OP_CMD, 8'h60);
      send(nbl_pkg::NBL_OP_CMD, 8'h10);
      chk("refuse_clr", refd, 1'b0);
      send(nbl_pkg::NBL_OP_WAIT, 8'h00);
      $display("t_prog done");
   endtask

   task automatic t_reset();
      int lim [3] = '{`NBL_RST_RD_US * 1000 / `NBL_CLK_NS,
                      `NBL_RST_PG_US * 1000 / `NBL_CLK_NS,
                      `NBL_RST_ER_US * 1000 / `NBL_CLK_NS};
      for (int a = 0; a < 3; a++) begin
         send(nbl_pkg::NBL_OP_CMD, `NBL_CMD_RESET, nbl_pkg::nbl_abort_t'(a));
         chk("rst_wait", cyc >= lim[a], 1'b1);
      end
      $display("t_reset done");
   endtask

   // Reset lands mid write strobe; the cut strobe must not latch
   task automatic t_midreset();
      logic [5:0] pv;
      @(negedge clk_i);
      req = '{op: nbl_pkg::NBL_OP_CMD, abort: nbl_pkg::NBL_AB_READ,
              data: `NBL_CMD_STATUS};
      req_valid = 1'b1;
      @(negedge clk_i);
      req_valid = 1'b0;
      repeat (4) @(negedge clk_i);
      chk("cut_low", pins.write_n, 1'b0);
      sys_rst_i = 1'b1;
      @(negedge clk_i);
      pv = {pins.cs_n, pins.write_n, pins.read_strobe_n,
            pins.cmd_latch, pins.addr_latch, pins.io_oe};
      chk("rst_pins", pv, 6'h38);
      chk("cut_ignored", dev_u.cmd_q, `NBL_CMD_RESET);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      chk("rst_rsp", {rsp_valid, req_ready}, 2'h1);
      $display("t_midreset done");
   endtask

   initial begin
      repeat (10) @(negedge clk_i);
      sys_rst_i = 1'b0;
      chk("idle_cs", pins.cs_n, 1'b1);
      t_read();
      t_status();
      t_prog();
      t_reset();
      t_midreset();
      t_status();
      chk("busy_strobes", viol, 0);
      end_of_test();
   end
endmodule
